// File: rrc_pkg.sv
// Constants, types and register map of the readout range configuration block.
package rrc_pkg;

  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned DATA_W        = 12;

  // Printed offsets are register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_CONFIG    = 8'h19;
  localparam logic [7:0]  IDX_MAG_STAT  = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG   = {2'h0, IDX_CONFIG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MAG_STAT = {2'h0, IDX_MAG_STAT, 2'h0};

  localparam logic [7:0]  CONFIG_RESET  = 8'h00;
  localparam int unsigned BIT_HIBERNATE = 0;
  localparam int unsigned BIT_Z_SKIP    = 1;
  localparam int unsigned BIT_Y_SKIP    = 2;
  localparam int unsigned BIT_X_SKIP    = 3;
  localparam int unsigned BIT_MAG_EN    = 4;
  localparam int unsigned BIT_MAG_BUSY  = 12;

  // Measurement result addresses walked by the burst sequencer.
  localparam logic [7:0]  ADDR_X_LOW    = 8'h04;
  localparam logic [7:0]  ADDR_Y_LOW    = 8'h06;
  localparam logic [7:0]  ADDR_Z_LOW    = 8'h08;
  localparam logic [7:0]  ADDR_MAG_LOW  = 8'h0a;

  localparam logic [1:0]  SRC_MAGNITUDE = 2'h1;
  localparam int unsigned ROOT_STEPS    = 12;
  localparam logic [23:0] ROOT_BIT_INIT = 24'h400000;
  localparam logic [3:0]  STEPS_LAST    = 4'hb;

  typedef enum logic [1:0] {
    RRC_IDLE   = 2'b00,
    RRC_SQUARE = 2'b01,
    RRC_ROOT   = 2'b11,
    RRC_DONE   = 2'b10
  } rrc_calc_state_t;

endpackage : rrc_pkg

// File: rrc_mag_if.sv
// Interface between the configuration top and the magnitude calculator.
`timescale 1ns/100ps
interface rrc_mag_if;
  logic                     start;
  logic signed [11:0]       x;
  logic signed [11:0]       y;
  logic signed [11:0]       z;
  logic                     done;
  logic [11:0]              mag;
  modport ctrl (output start, output x, output y, output z, input done, input mag);
  modport calc (input start, input x, input y, input z, output done, output mag);
endinterface : rrc_mag_if

// File: rrc_magnitude.sv
// Iterative square root of the sum of axis squares, twelve result bits.
`timescale 1ns/100ps
module rrc_magnitude
  import rrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  rrc_mag_if.calc   mif
);

  typedef struct packed {
    rrc_calc_state_t state;
    logic [23:0]     num;
    logic [23:0]     res;
    logic [23:0]     rbit;
    logic [3:0]      step;
    logic            done;
    logic [11:0]     mag;
  } rrc_mag_state_t;

  rrc_mag_state_t cur;
  rrc_mag_state_t next_cur;

  function automatic logic [23:0] rrc_square(input logic signed [11:0] v);
    logic signed [23:0] w;
    w = 24'(v);
    return 24'(w * w);
  endfunction : rrc_square

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    unique case (cur.state)
      RRC_IDLE: begin
        if (mif.start) begin
          next_cur.state = RRC_SQUARE;
        end
      end
      RRC_SQUARE: begin
        // Sum cannot exceed 3 * 2048^2, which fits the 24-bit radicand.
        next_cur.num   = rrc_square(mif.x) + rrc_square(mif.y) + rrc_square(mif.z);
        next_cur.res   = 24'h000000;
        next_cur.rbit  = ROOT_BIT_INIT;
        next_cur.step  = 4'h0;
        next_cur.state = RRC_ROOT;
      end
      RRC_ROOT: begin
        if (cur.num >= cur.res + cur.rbit) begin
          next_cur.num = cur.num - (cur.res + cur.rbit);
          next_cur.res = (cur.res >> 1) + cur.rbit;
        end else begin
          next_cur.res = cur.res >> 1;
        end
        next_cur.rbit = cur.rbit >> 2;
        next_cur.step = cur.step + 4'h1;
        if (cur.step == STEPS_LAST) begin
          next_cur.state = RRC_DONE;
        end
      end
      RRC_DONE: begin
        next_cur.mag   = cur.res[11:0];
        next_cur.done  = 1'b1;
        next_cur.state = RRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign mif.done = cur.done;
  assign mif.mag  = cur.mag;

endmodule : rrc_magnitude

// File: rrc_readout_config.sv
// Readout range configuration: APB register, burst address sequencer, magnitude control.
`timescale 1ns/100ps
module rrc_readout_config
  import rrc_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     odrTick,
  input  wire logic signed [DATA_W-1:0] xData,
  input  wire logic signed [DATA_W-1:0] yData,
  input  wire logic signed [DATA_W-1:0] zData,
  input  wire logic                     burstStart,
  input  wire logic [7:0]               burstAddr,
  input  wire logic                     burstAdvance,
  output logic [7:0]                    seqAddr,
  input  wire logic [1:0]               detectorSource,
  output logic [DATA_W-1:0]             detectorInput,
  output logic [DATA_W-1:0]             magnitude,
  output logic                          magnitudeValid,
  output logic                          magnitudeEnable,
  output logic                          hibernateRequest
);

  typedef struct packed {
    logic [7:0]        cfg;
    logic [31:0]       rdata;
    logic              ready;
    logic              err;
    logic [7:0]        addr;
    logic              skipX;
    logic              skipY;
    logic              skipZ;
    logic              skipMag;
    logic              start;
    logic              busy;
    logic [DATA_W-1:0] mag;
    logic              magValid;
    logic [DATA_W-1:0] detIn;
  } rrc_top_state_t;

  rrc_top_state_t cur;
  rrc_top_state_t next_cur;

  rrc_mag_if mif ();

  rrc_magnitude u_magnitude (
    .clk   (clk),
    .rst_n (rst_n),
    .mif   (mif)
  );

  // True when the address is one of the two bytes of a result that is skipped.
  function automatic logic rrc_skipped(input logic [7:0] a, input logic sx, input logic sy,
                                       input logic sz, input logic sm);
    logic [7:0] base;
    base = {a[7:1], 1'b0};
    return (sx && base == ADDR_X_LOW) || (sy && base == ADDR_Y_LOW) ||
           (sz && base == ADDR_Z_LOW) || (sm && base == ADDR_MAG_LOW);
  endfunction : rrc_skipped

  // Skipped results come in pairs of bytes, so eight steps cover all four results.
  function automatic logic [7:0] rrc_next_addr(input logic [7:0] a, input logic sx,
                                               input logic sy, input logic sz, input logic sm);
    logic [7:0] n;
    n = a + 8'h01;
    for (int i = 0; i < 8; i++) begin
      if (rrc_skipped(n, sx, sy, sz, sm)) begin
        n = n + 8'h01;
      end
    end
    return n;
  endfunction : rrc_next_addr

  always_comb begin
    logic setup;
    logic access;
    logic cfgHit;
    logic statHit;
    logic sx;
    logic sy;
    logic sz;
    logic sm;
    sx      = 1'b0;
    sy      = 1'b0;
    sz      = 1'b0;
    sm      = 1'b0;
    setup   = psel && !penable;
    access  = psel && penable && cur.ready;
    cfgHit  = paddr == ADDR_CONFIG;
    statHit = paddr == ADDR_MAG_STAT;
    next_cur = cur;
    next_cur.start    = 1'b0;
    next_cur.magValid = 1'b0;

    // One wait-free access phase; unmapped addresses answer with an error.
    next_cur.ready = setup;
    if (setup) begin
      next_cur.err   = !(cfgHit || statHit) || (statHit && pwrite);
      next_cur.rdata = 32'h00000000;
      if (cfgHit) begin
        next_cur.rdata[7:0] = cur.cfg;
      end else if (statHit) begin
        next_cur.rdata[DATA_W-1:0] = cur.mag;
        next_cur.rdata[BIT_MAG_BUSY] = cur.busy;
      end
    end else begin
      next_cur.err = 1'b0;
    end
    if (access && pwrite && cfgHit) begin
      next_cur.cfg = pwdata[7:0];
    end

    // Skip settings are sampled only when a burst begins, never in mid-burst.
    if (burstStart) begin
      sx = cur.cfg[BIT_X_SKIP];
      sy = cur.cfg[BIT_Y_SKIP];
      sz = cur.cfg[BIT_Z_SKIP];
      sm = !cur.cfg[BIT_MAG_EN];
      next_cur.skipX   = sx;
      next_cur.skipY   = sy;
      next_cur.skipZ   = sz;
      next_cur.skipMag = sm;
      if (rrc_skipped(burstAddr, sx, sy, sz, sm)) begin
        next_cur.addr = rrc_next_addr(burstAddr, sx, sy, sz, sm);
      end else begin
        next_cur.addr = burstAddr;
      end
    end else if (burstAdvance) begin
      next_cur.addr = rrc_next_addr(cur.addr, cur.skipX, cur.skipY, cur.skipZ, cur.skipMag);
    end

    // A tick that lands while a calculation runs is dropped rather than queued.
    if (odrTick && cur.cfg[BIT_MAG_EN] && !cur.busy) begin
      next_cur.start = 1'b1;
      next_cur.busy  = 1'b1;
    end
    if (!cur.cfg[BIT_MAG_EN] && !cur.busy) begin
      next_cur.start = 1'b0;
    end
    if (mif.done) begin
      next_cur.busy     = 1'b0;
      next_cur.mag      = mif.mag;
      next_cur.magValid = 1'b1;
    end

    if (detectorSource == SRC_MAGNITUDE) begin
      next_cur.detIn = cur.mag;
    end else begin
      next_cur.detIn = 12'(xData);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur     <= '0;
      cur.cfg <= CONFIG_RESET;
      // An advance before any start must still skip the magnitude bytes of a reset config.
      cur.skipMag <= !CONFIG_RESET[BIT_MAG_EN];
    end else begin
      cur <= next_cur;
    end
  end

  // Axis samples are held by the data path for the whole calculation window.
  assign mif.start = cur.start;
  assign mif.x     = xData;
  assign mif.y     = yData;
  assign mif.z     = zData;

  assign prdata           = cur.rdata;
  assign pready           = cur.ready;
  assign pslverr          = cur.err;
  assign seqAddr          = cur.addr;
  assign detectorInput    = cur.detIn;
  assign magnitude        = cur.mag;
  assign magnitudeValid   = cur.magValid;
  assign magnitudeEnable  = cur.cfg[BIT_MAG_EN];
  assign hibernateRequest = cur.cfg[BIT_HIBERNATE];

endmodule : rrc_readout_config

// File: rrc_readout_config_sva.sv
// Concurrent checks on the readout range configuration ports.
`timescale 1ns/100ps
module rrc_readout_config_sva
  import rrc_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              odrTick,
  input wire logic              burstStart,
  input wire logic              burstAdvance,
  input wire logic [7:0]        seqAddr,
  input wire logic              magnitudeValid,
  input wire logic              magnitudeEnable
);
  logic [7:0] cfg;
  logic       wrCfg;
  assign wrCfg = psel && penable && pready && pwrite && paddr == ADDR_CONFIG;
  // A shadow copy, because only the hibernate and enable bits of the register show at the ports.
  always_ff @(posedge clk) begin
    if (!rst_n) cfg <= 8'h00;
    else if (wrCfg) cfg <= pwdata[7:0];
  end
  // A burst keeps the skips seen at its start, and a running calculation ignores ticks.
  logic [7:0] burstCfg;
  logic [4:0] calcLeft;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      burstCfg <= 8'h00;
      calcLeft <= 5'h00;
    end else begin
      if (burstStart) burstCfg <= cfg;
      if (odrTick && magnitudeEnable && calcLeft == 5'h00) calcLeft <= 5'h10;
      else if (calcLeft != 5'h00) calcLeft <= calcLeft - 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_tick; odrTick && magnitudeEnable && calcLeft == 5'h00; endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_enable_follows: assert property (wrCfg |-> ##2 magnitudeEnable == cfg[4])
    else $error("enable not from config");
  chk_mag_latency: assert property (s_tick |-> ##17 magnitudeValid)
    else $error("magnitude late");
  chk_valid_needs_en: assert property (magnitudeValid |-> $past(magnitudeEnable, 17))
    else $error("magnitude while disabled");
  chk_valid_pulse: assert property (magnitudeValid |=> !magnitudeValid)
    else $error("valid too long");
  chk_x_skip: assert property ($past(burstStart || burstAdvance) |->
    !(seqAddr[7:1] == ADDR_X_LOW[7:1] && burstCfg[3])) else $error("x not skipped");
  chk_y_skip: assert property ($past(burstStart || burstAdvance) |->
    !(seqAddr[7:1] == ADDR_Y_LOW[7:1] && burstCfg[2])) else $error("y not skipped");
  chk_z_skip: assert property ($past(burstStart || burstAdvance) |->
    !(seqAddr[7:1] == ADDR_Z_LOW[7:1] && burstCfg[1])) else $error("z not skipped");
  chk_mag_skip: assert property ($past(burstStart || burstAdvance) |->
    !(seqAddr[7:1] == ADDR_MAG_LOW[7:1] && !burstCfg[4])) else $error("mag kept");
endmodule : rrc_readout_config_sva
bind rrc_readout_config rrc_readout_config_sva chk (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .odrTick, .burstStart, .burstAdvance, .seqAddr, .magnitudeValid,
  .magnitudeEnable);

// File: rrc_readout_config_test.sv
// Self-checking bench for the readout range configuration block.
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module rrc_readout_config_test
  import rrc_pkg::*;
;
  logic              clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic              odrTick = 0, burstStart = 0, burstAdvance = 0;
  logic              pready, pslverr, magnitudeValid, magnitudeEnable, hib;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata;
  logic [11:0]       xData = 12'h000, yData = 12'h000, zData = 12'h000;
  logic [11:0]       detectorInput, magnitude;
  logic [7:0]        burstAddr = 8'h00, seqAddr;
  logic [1:0]        detectorSource = 2'h0;
  int                errors = 0, checked = 0;
  always #25 clk = ~clk;
  rrc_readout_config dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .odrTick(odrTick), .xData(xData), .yData(yData), .zData(zData),
    .burstStart(burstStart), .burstAddr(burstAddr), .burstAdvance(burstAdvance),
    .seqAddr(seqAddr), .detectorSource(detectorSource), .detectorInput(detectorInput),
    .magnitude(magnitude), .magnitudeValid(magnitudeValid),
    .magnitudeEnable(magnitudeEnable), .hibernateRequest(hib));
  task test_done;
    if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic er);
    int n;
    @(posedge clk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk); penable <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin errors++; test_done(); end
    if (!w && !er) `CHK(prdata, e)
    `CHK(pslverr, er)
    psel <= 0; penable <= 0;
  endtask : apb
  function automatic logic kept(logic [7:0] a, logic [7:0] c);
    case (a[7:1])
      ADDR_X_LOW[7:1]: kept = !c[3];
      ADDR_Y_LOW[7:1]: kept = !c[2];
      ADDR_Z_LOW[7:1]: kept = !c[1];
      ADDR_MAG_LOW[7:1]: kept = c[4];
      default: kept = 1'b1;
    endcase
  endfunction : kept
  // Skipped pairs are stepped over, so a start on one lands on the next kept byte.
  function automatic logic [7:0] fwd(logic [7:0] a, logic [7:0] c);
    fwd = a;
    while (!kept(fwd, c)) fwd = fwd + 8'h01;
  endfunction : fwd
  task burst(input logic [7:0] c, a);
    logic [7:0] e;
    apb(1, ADDR_CONFIG, {24'h0, c}, 32'h0, 0);
    e = fwd(a, c);
    @(posedge clk); burstStart <= 1; burstAddr <= a;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk); burstStart <= 0; burstAdvance <= (i < 9);
      @(negedge clk); `CHK(seqAddr, e)
      e = fwd(e + 8'h01, c);
    end
  endtask : burst
  initial begin
    int n, k;
    logic [7:0] cfgs[6];
    cfgs = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h10, 8'h1e};
    repeat (8) @(posedge clk);
    rst_n <= 1;
    apb(0, ADDR_CONFIG, 0, 32'h0, 0);
    apb(1, ADDR_CONFIG, 32'hff, 0, 0); apb(0, ADDR_CONFIG, 0, 32'hff, 0);
    `CHK({hib, magnitudeEnable}, 2'b11)
    apb(0, 12'h000, 0, 0, 1); apb(1, ADDR_MAG_STAT, 1, 0, 1);
    for (k = 0; k < 6; k++) burst(cfgs[k], 8'h03);
    burst(8'h08, ADDR_X_LOW);
    apb(1, ADDR_CONFIG, 32'h10, 0, 0);
    @(posedge clk); xData <= 12'h003; yData <= 12'h004; zData <= 12'h00c;
    @(posedge clk); odrTick <= 1;
    @(posedge clk); odrTick <= 0;
    apb(0, ADDR_MAG_STAT, 0, 32'h1000, 0);
    n = 0;
    do begin @(negedge clk); n++; end while (magnitudeValid !== 1'b1 && n < 30);
    if (magnitudeValid !== 1'b1) begin errors++; test_done(); end
    `CHK(magnitude, 12'h00d)
    apb(0, ADDR_MAG_STAT, 0, 32'hd, 0);
    for (k = 0; k < 2; k++) begin
      @(posedge clk); detectorSource <= 2'(1 - k);
      @(posedge clk); @(negedge clk); `CHK(detectorInput, k ? 12'h003 : 12'h00d)
    end
    apb(1, ADDR_CONFIG, 0, 0, 0);
    @(posedge clk); odrTick <= 1;
    @(posedge clk); odrTick <= 0;
    n = 0;
    repeat (20) begin @(negedge clk); n += int'(magnitudeValid !== 1'b0); end
    `CHK(n, 0)
    test_done();
  end
endmodule : rrc_readout_config_test
